/* File: exec_pkg.sv */
// Constants and types for the displacement move and multiply execution block
package exec_pkg;
  localparam int unsigned XLEN = 32;
  localparam int unsigned CLK_MHZ = 25;
  // Opcode match values and masks
  localparam logic [15:0] OP_MASK_HI4 = 16'hf000;
  localparam logic [15:0] OP_MASK_HI8 = 16'hff00;
  localparam logic [15:0] OP_MASK_FLAG = 16'hf0ff;
  localparam logic [15:0] OP_MASK_MUL = 16'hf00f;
  localparam logic [15:0] OP_STORE_B = 16'h8000;
  localparam logic [15:0] OP_STORE_W = 16'h8100;
  localparam logic [15:0] OP_STORE_L = 16'h1000;
  localparam logic [15:0] OP_LOAD_B = 16'h8400;
  localparam logic [15:0] OP_LOAD_W = 16'h8500;
  localparam logic [15:0] OP_LOAD_L = 16'h5000;
  localparam logic [15:0] OP_PC_ADDR = 16'hc700;
  localparam logic [15:0] OP_FLAG_COPY = 16'h0029;
  localparam logic [15:0] OP_MUL32 = 16'h0007;
  localparam logic [15:0] OP_MULS16 = 16'h200f;
  // Address arithmetic
  localparam logic [31:0] PC_ALIGN_MASK = 32'hfffffffc;
  localparam logic [31:0] PC_AHEAD = 32'h00000004;
  localparam logic [31:0] PC_STEP = 32'h00000002;
  localparam logic [31:0] SLOT_OFFSET = 32'h00000002;
  // Multiplier latency in cycles (counted after the issue cycle)
  localparam logic [1:0] MUL32_CYCLES = 2'd2;
  localparam logic [1:0] MULS16_CYCLES = 2'd1;
  localparam logic [31:0] RESET_PC = 32'h00000000;
  localparam logic [3:0] REG_ZERO = 4'h0;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_LONG = 2'b10
  } size_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM = 2'b01,
    ST_MUL = 2'b11
  } state_type;

  typedef enum logic [3:0] {
    K_NONE, K_STB, K_STW, K_STL, K_LDB, K_LDW, K_LDL, K_PCA, K_FLAG, K_MUL32, K_MULS16
  } kind_type;

  // Opcode classifier, used by the issue logic and the interlock check
  function automatic kind_type classify(input logic [15:0] op);
    kind_type k;
    k = K_NONE;
    if ((op & OP_MASK_HI8) == OP_STORE_B) k = K_STB;
    else if ((op & OP_MASK_HI8) == OP_STORE_W) k = K_STW;
    else if ((op & OP_MASK_HI4) == OP_STORE_L) k = K_STL;
    else if ((op & OP_MASK_HI8) == OP_LOAD_B) k = K_LDB;
    else if ((op & OP_MASK_HI8) == OP_LOAD_W) k = K_LDW;
    else if ((op & OP_MASK_HI4) == OP_LOAD_L) k = K_LDL;
    else if ((op & OP_MASK_HI8) == OP_PC_ADDR) k = K_PCA;
    else if ((op & OP_MASK_FLAG) == OP_FLAG_COPY) k = K_FLAG;
    else if ((op & OP_MASK_MUL) == OP_MUL32) k = K_MUL32;
    else if ((op & OP_MASK_MUL) == OP_MULS16) k = K_MULS16;
    return k;
  endfunction : classify
endpackage : exec_pkg

/* File: exec_regfile.sv */
// Sixteen-entry general register file with registered read ports
`timescale 1ns/1ps
module exec_regfile
  import exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] ra_i,
  input wire logic [3:0] rb_i,
  output logic [31:0] ra_data_o,
  output logic [31:0] rb_data_o,
  output logic [31:0] r0_data_o,
  input wire logic we_i,
  input wire logic [3:0] wa_i,
  input wire logic [31:0] wd_i
);
  logic [31:0] mem_q [16];

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_reg
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          mem_q[g] <= '0;
        end else if (we_i && wa_i == 4'(g)) begin
          mem_q[g] <= wd_i;
        end
      end
    end
  endgenerate

  // Read data come out of registers; write-through keeps the next read current
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ra_data_o <= '0;
      rb_data_o <= '0;
    end else begin
      ra_data_o <= (we_i && wa_i == ra_i) ? wd_i : mem_q[ra_i];
      rb_data_o <= (we_i && wa_i == rb_i) ? wd_i : mem_q[rb_i];
    end
  end

  assign r0_data_o = mem_q[0];
endmodule : exec_regfile

/* File: disp_move_and_multiply_exec.sv */
// Execution unit for displacement moves, PC-relative address, flag copy and multiplies
//
// Behaviour
// - Byte store writes low byte of register zero to base plus displacement.
// - Halfword store writes low halfword of register zero to base plus twice displacement.
// - Longword store writes source register to base plus four times displacement.
// - Byte load sign-extends byte from base plus displacement into register zero.
// - Halfword load sign-extends halfword at base plus twice displacement into register zero.
// - Longword load reads base plus four times displacement into destination register.
// - PC-relative address adds four times 8-bit displacement to base, one cycle.
// - PC base is instruction address plus four, low two bits cleared.
// - In a delayed-branch slot the base is branch target plus two, low two bits cleared.
// - Flag copy writes flag into bit 0, other bits zero, one cycle.
// - 32-bit multiply keeps low product in low accumulator, two to four cycles.
// - Signed halfword multiply writes 32-bit product to low accumulator, one to three cycles.
// - Next instruction reading register zero stalls until byte/halfword load ends.
`timescale 1ns/1ps
module disp_move_and_multiply_exec
  import exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Instruction issue
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [31:0] instr_addr_i,
  input wire logic in_delay_slot_i,
  input wire logic [31:0] branch_target_i,
  input wire logic flag_i,
  output logic instr_ready_o,
  output logic busy_o,
  output logic r0_hazard_o,
  // Data memory port
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [1:0] mem_size_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Results
  output logic [31:0] low_accumulator_o,
  output logic [31:0] high_accumulator_o,
  output logic [31:0] next_pc_o,
  output logic flag_o,
  output logic retire_o,
  output logic [31:0] general_register_zero_o
);
  // ---------------------------------------------------------------
  // Decode and operand fetch
  // ---------------------------------------------------------------
  state_type state_q;
  kind_type kind_q;
  logic [15:0] op_q;
  logic [31:0] pc_base_q;
  logic [31:0] pc_q;
  logic flag_q;
  logic [31:0] ra_data, rb_data, r0_data;
  logic [1:0] mul_cnt_q;
  logic [31:0] low_accumulator_q;
  logic [31:0] high_accumulator_q;
  logic rf_we;
  logic [3:0] rf_wa;
  logic [31:0] rf_wd;
  logic load_r0_pending;
  kind_type new_kind;

  assign new_kind = classify(instr_i);
  // Register fields: hi nibble group [11:8], mid [7:4]
  logic [3:0] fld_n, fld_m;
  assign fld_n = op_q[11:8];
  assign fld_m = op_q[7:4];

  // Read port A gives the base or first factor, B the data or second factor
  logic [3:0] rd_a, rd_b;
  always_comb begin
    rd_a = instr_i[11:8];
    rd_b = instr_i[7:4];
    unique case (new_kind)
      K_STB, K_STW: begin
        rd_a = instr_i[7:4];
        rd_b = REG_ZERO;
      end
      K_LDB, K_LDW: begin
        rd_a = instr_i[7:4];
        rd_b = REG_ZERO;
      end
      K_LDL: begin
        rd_a = instr_i[7:4];
        rd_b = instr_i[7:4];
      end
      default: begin
        rd_a = instr_i[11:8];
        rd_b = instr_i[7:4];
      end
    endcase
  end

  exec_regfile u_regfile (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ra_i(rd_a),
    .rb_i(rd_b),
    .ra_data_o(ra_data),
    .rb_data_o(rb_data),
    .r0_data_o(r0_data),
    .we_i(rf_we),
    .wa_i(rf_wa),
    .wd_i(rf_wd)
  );

  // Stall a new instruction that names register zero while a narrow load is in flight
  logic new_uses_r0;
  assign new_uses_r0 = (new_kind != K_NONE) && (rd_a == REG_ZERO || rd_b == REG_ZERO);
  assign load_r0_pending = (state_q == ST_MEM) && (kind_q == K_LDB || kind_q == K_LDW);
  assign r0_hazard_o = load_r0_pending && instr_valid_i && new_uses_r0;
  assign instr_ready_o = (state_q == ST_IDLE);
  assign busy_o = (state_q != ST_IDLE);

  logic accept;
  assign accept = instr_valid_i && instr_ready_o && (new_kind != K_NONE);

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  logic exec_q;
  logic done;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      exec_q <= 1'b0;
      kind_q <= K_NONE;
      op_q <= '0;
      pc_base_q <= '0;
      mul_cnt_q <= '0;
    end else begin
      exec_q <= accept;
      if (accept) begin
        state_q <= ST_MEM;
        kind_q <= new_kind;
        op_q <= instr_i;
        // Base taken at issue so the branch target is still valid
        // The low two bits are cleared in the delay slot as well, since the slot value stands in for the PC
        pc_base_q <= (in_delay_slot_i ? (branch_target_i + SLOT_OFFSET)
                                      : (instr_addr_i + PC_AHEAD)) & PC_ALIGN_MASK;
        mul_cnt_q <= (new_kind == K_MUL32) ? MUL32_CYCLES : MULS16_CYCLES;
      end else if (state_q == ST_MEM && exec_q) begin
        unique case (kind_q)
          K_STB, K_STW, K_STL, K_LDB, K_LDW, K_LDL: state_q <= mem_ack_i ? ST_IDLE : ST_MEM;
          K_MUL32, K_MULS16: state_q <= (mul_cnt_q == 2'd1) ? ST_IDLE : ST_MUL;
          default: state_q <= ST_IDLE;
        endcase
        if (mul_cnt_q != 2'd0) begin
          mul_cnt_q <= mul_cnt_q - 2'd1;
        end
      end else if (state_q == ST_MEM) begin
        if (mem_ack_i) begin
          state_q <= ST_IDLE;
        end
      end else if (state_q == ST_MUL) begin
        state_q <= ST_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Address and data path
  // ---------------------------------------------------------------
  logic [31:0] disp4_b, disp4_w, disp4_l, ea;
  assign disp4_b = {28'h0000000, op_q[3:0]};
  assign disp4_w = {27'h0, op_q[3:0], 1'b0};
  assign disp4_l = {26'h0, op_q[3:0], 2'b00};

  size_type size;
  always_comb begin
    ea = ra_data + disp4_l;
    size = SIZE_LONG;
    unique case (kind_q)
      K_STB, K_LDB: begin
        ea = ra_data + disp4_b;
        size = SIZE_BYTE;
      end
      K_STW, K_LDW: begin
        ea = ra_data + disp4_w;
        size = SIZE_HALF;
      end
      default: begin
        ea = ra_data + disp4_l;
        size = SIZE_LONG;
      end
    endcase
  end

  logic is_mem, is_store;
  assign is_mem = kind_q inside {K_STB, K_STW, K_STL, K_LDB, K_LDW, K_LDL};
  assign is_store = kind_q inside {K_STB, K_STW, K_STL};

  // Address and data held in flops for the whole access until acknowledge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_size_o <= SIZE_LONG;
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
    end else if (exec_q && is_mem) begin
      mem_req_o <= 1'b1;
      mem_we_o <= is_store;
      mem_size_o <= size;
      mem_addr_o <= ea;
      unique case (kind_q)
        K_STB: mem_wdata_o <= {24'h000000, rb_data[7:0]};
        K_STW: mem_wdata_o <= {16'h0000, rb_data[15:0]};
        default: mem_wdata_o <= rb_data;
      endcase
    end else if (mem_ack_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register write-back
  // ---------------------------------------------------------------
  logic load_done;
  assign load_done = mem_req_o && mem_ack_i && !mem_we_o;

  always_comb begin
    rf_we = 1'b0;
    rf_wa = REG_ZERO;
    rf_wd = '0;
    if (load_done) begin
      rf_we = 1'b1;
      unique case (kind_q)
        K_LDB: rf_wd = {{24{mem_rdata_i[7]}}, mem_rdata_i[7:0]};
        K_LDW: rf_wd = {{16{mem_rdata_i[15]}}, mem_rdata_i[15:0]};
        default: begin
          rf_wa = fld_n;
          rf_wd = mem_rdata_i;
        end
      endcase
    end else if (exec_q && kind_q == K_PCA) begin
      rf_we = 1'b1;
      rf_wd = pc_base_q + {22'h0, op_q[7:0], 2'b00};
    end else if (exec_q && kind_q == K_FLAG) begin
      rf_we = 1'b1;
      rf_wa = fld_n;
      rf_wd = {31'h0, flag_q};
    end
  end

  // ---------------------------------------------------------------
  // Multiplier; the high accumulator is never written here
  // ---------------------------------------------------------------
  logic [63:0] prod_full;
  logic signed [31:0] prod_half;
  assign prod_full = {32'h0, ra_data} * {32'h0, rb_data};
  assign prod_half = 32'($signed(ra_data[15:0])) * 32'($signed(rb_data[15:0]));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      low_accumulator_q <= '0;
      high_accumulator_q <= '0;
    end else if (exec_q && kind_q == K_MUL32) begin
      low_accumulator_q <= prod_full[31:0];
    end else if (exec_q && kind_q == K_MULS16) begin
      low_accumulator_q <= prod_half;
    end
  end

  assign low_accumulator_o = low_accumulator_q;
  assign high_accumulator_o = high_accumulator_q;
  assign general_register_zero_o = r0_data;

  // ---------------------------------------------------------------
  // Program counter and flag
  // ---------------------------------------------------------------
  assign done = (state_q != ST_IDLE) && (state_q == ST_MUL ||
                (state_q == ST_MEM && exec_q && !is_mem && !(kind_q inside {K_MUL32}) ) ||
                (mem_req_o && mem_ack_i));

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_q <= RESET_PC;
      flag_q <= 1'b0;
      retire_o <= 1'b0;
    end else begin
      retire_o <= done;
      if (accept) begin
        flag_q <= flag_i;
        pc_q <= instr_addr_i + PC_STEP;
      end
    end
  end

  assign next_pc_o = pc_q;
  assign flag_o = flag_q;
endmodule : disp_move_and_multiply_exec

/* File: disp_move_and_multiply_exec_props.sv */
// Port checker for the displacement move and multiply execution block
`timescale 1ns/1ps
module disp_move_and_multiply_exec_props
  import exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [31:0] instr_addr_i,
  input wire logic in_delay_slot_i,
  input wire logic [31:0] branch_target_i,
  input wire logic instr_ready_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [1:0] mem_size_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic [31:0] high_accumulator_o,
  input wire logic retire_o,
  input wire logic [31:0] general_register_zero_o
);
  // ----
  // Issue tracking
  // ----
  logic acc;
  logic [31:0] pbase;
  logic [31:0] pca_q;
  assign acc = instr_valid_i & instr_ready_o;
  assign pbase = in_delay_slot_i ? branch_target_i + SLOT_OFFSET : instr_addr_i + PC_AHEAD;
  // Captured at issue, since the inputs may move before the result lands
  always_ff @(posedge clk_i) begin
    if (acc) pca_q <= (pbase & PC_ALIGN_MASK) + {22'h0, instr_i[7:0], 2'h0};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_pca_result: assert property (acc && (instr_i & OP_MASK_HI8) == OP_PC_ADDR
    |-> ##[1:4] retire_o && general_register_zero_o == pca_q) else $error("pc relative result wrong");
  chk_byte_store: assert property (mem_req_o && mem_we_o && mem_size_o == 2'd0
    |-> mem_wdata_o[31:8] == 24'h0) else $error("byte store upper lanes set");
  chk_half_store: assert property (mem_req_o && mem_we_o && mem_size_o == 2'd1
    |-> mem_wdata_o[31:16] == 16'h0) else $error("half store upper lanes set");
  chk_long_store: assert property (acc && (instr_i & OP_MASK_HI4) == OP_STORE_L
    |-> ##[1:4] mem_req_o && mem_we_o && mem_size_o == 2'd2) else $error("long store cycle missing");
  chk_byte_load: assert property (mem_req_o && mem_ack_i && !mem_we_o && mem_size_o == 2'd0
    |=> general_register_zero_o == {{24{$past(mem_rdata_i[7])}}, $past(mem_rdata_i[7:0])})
    else $error("byte load extension wrong");
  chk_half_load: assert property (mem_req_o && mem_ack_i && !mem_we_o && mem_size_o == 2'd1
    |=> general_register_zero_o == {{16{$past(mem_rdata_i[15])}}, $past(mem_rdata_i[15:0])})
    else $error("half load extension wrong");
  chk_long_load: assert property (acc && (instr_i & OP_MASK_HI4) == OP_LOAD_L
    |-> ##[1:4] mem_req_o && !mem_we_o && mem_size_o == 2'd2) else $error("long load cycle missing");
  chk_flag_time: assert property (acc && (instr_i & OP_MASK_FLAG) == OP_FLAG_COPY
    |-> ##[1:3] retire_o) else $error("flag copy too slow");
  chk_mul_time: assert property (acc && (instr_i & OP_MASK_MUL) == OP_MUL32
    |=> !retire_o ##[1:4] retire_o) else $error("multiply latency wrong");
  chk_high_acc: assert property ($stable(high_accumulator_o)) else $error("high accumulator moved");
  chk_narrow_lock: assert property (acc && (instr_i & 16'hfe00) == OP_LOAD_B
    |=> !instr_ready_o [*2]) else $error("narrow load not interlocked");
endmodule : disp_move_and_multiply_exec_props

bind disp_move_and_multiply_exec disp_move_and_multiply_exec_props u_props (.clk_i, .sys_rst_i,
  .instr_valid_i, .instr_i, .instr_addr_i, .in_delay_slot_i, .branch_target_i, .instr_ready_o, .mem_req_o,
  .mem_we_o, .mem_size_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .high_accumulator_o, .retire_o,
  .general_register_zero_o);

/* File: mem_partner.sv */
// Data memory model with random answer delay
`timescale 1ns/1ps
module mem_partner (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [1:0] mem_size_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  // ----
  // Storage and answer
  // ----
  logic [31:0] mem [logic [31:0]];
  logic [31:0] last_addr;
  logic [31:0] last_data;
  logic [1:0] last_size;
  logic [31:0] lane;
  logic [31:0] nz;
  integer seed = 32'h372f3542;
  int wait_q = 0;
  always @(posedge clk_i) begin
    nz = $random(seed);
    mem_ack_o <= 1'b0;
    // Idle bus shows noise so a stale value is never mistaken for data
    mem_rdata_o <= nz;
    if (sys_rst_i) wait_q <= 0;
    else if (mem_req_i && !mem_ack_o) begin
      if (wait_q == 0) begin
        lane = mem.exists(mem_addr_i) ? mem[mem_addr_i] : nz;
        mem_ack_o <= 1'b1;
        wait_q <= nz[5:4];
        // Unused upper lanes of narrow reads carry noise
        mem_rdata_o <= mem_size_i == 2'd0 ? {nz[31:8], lane[7:0]} :
          mem_size_i == 2'd1 ? {nz[31:16], lane[15:0]} : lane;
        if (mem_we_i) begin
          mem[mem_addr_i] = mem_wdata_i;
          last_addr <= mem_addr_i;
          last_data <= mem_wdata_i;
          last_size <= mem_size_i;
        end
      end else wait_q <= wait_q - 1;
    end
  end
endmodule : mem_partner

/* File: disp_move_and_multiply_exec_tb_top.sv */
// Self-checking bench for the execution block
`timescale 1ns/1ps
`define CMP(nm, e, s) begin checks++; if ((e) !== (s)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module disp_move_and_multiply_exec_tb_top import exec_pkg::*; ;
  logic clk_i = 0, sys_rst_i = 1, instr_valid_i = 0, in_delay_slot_i = 0, flag_i = 0, mem_ack_i;
  logic [15:0] instr_i = 16'h0;
  logic [31:0] instr_addr_i = 32'h0, branch_target_i = 32'h0, mem_rdata_i;
  logic instr_ready_o, busy_o, r0_hazard_o, mem_req_o, mem_we_o, flag_o, retire_o;
  logic [1:0] mem_size_o;
  logic [31:0] mem_addr_o, mem_wdata_o, low_accumulator_o, high_accumulator_o, next_pc_o, general_register_zero_o;
  int mismatches = 0, checks = 0, cyc = 0;
  integer seed = 32'h372f3542;
  logic [31:0] r [16] = '{default: 32'h0};
  logic [31:0] low_accumulator = 32'h0;
  disp_move_and_multiply_exec dut (.clk_i, .sys_rst_i, .instr_valid_i, .instr_i, .instr_addr_i,
    .in_delay_slot_i, .branch_target_i, .flag_i, .instr_ready_o, .busy_o, .r0_hazard_o, .mem_req_o, .mem_we_o,
    .mem_size_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .low_accumulator_o, .high_accumulator_o,
    .next_pc_o, .flag_o, .retire_o, .general_register_zero_o);
  mem_partner u_mem (.clk_i, .sys_rst_i, .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_size_i(mem_size_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  always #20 clk_i = ~clk_i;
  // ----
  // Tasks
  // ----
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // One instruction: model computes the access, the bench issues it and compares
  task automatic step(input int k, input logic [3:0] n, input logic [3:0] m, input logic [3:0] d);
    logic [15:0] op;
    logic [31:0] ea, wd, v;
    logic [7:0] d8;
    int t;
    v = $random(seed);
    d8 = {m, d};
    case (k)
      0: begin op = {8'h80, n, d}; ea = r[n] + 32'(d); wd = {24'h0, r[0][7:0]}; end
      1: begin op = {8'h81, n, d}; ea = r[n] + 32'({d, 1'b0}); wd = {16'h0, r[0][15:0]}; end
      2: begin op = {4'h1, n, m, d}; ea = r[n] + 32'({d, 2'b0}); wd = r[m]; end
      3: begin op = {8'h84, m, d}; ea = r[m] + 32'(d); end
      4: begin op = {8'h85, m, d}; ea = r[m] + 32'({d, 1'b0}); end
      5: begin op = {4'h5, n, m, d}; ea = r[m] + 32'({d, 2'b0}); end
      6: op = {8'hc7, d8};
      7: op = {4'h0, n, 8'h29};
      8: op = {4'h0, n, m, 4'h7};
      default: op = {4'h2, n, m, 4'hf};
    endcase
    if (k >= 3 && k <= 5) u_mem.mem[ea] = v;
    t = 0;
    @(negedge clk_i);
    while (instr_ready_o !== 1'b1 && t < 50) begin @(negedge clk_i); t++; end
    if (t >= 50) mismatches++;
    instr_i = op;
    instr_addr_i = $random(seed) & 32'hfffffffe;
    branch_target_i = $random(seed) & 32'hfffffffe;
    in_delay_slot_i = k == 6 ? v[3] : 1'b0;
    flag_i = v[9];
    instr_valid_i = 1'b1;
    @(negedge clk_i);
    // Offer still standing while the first is in flight: nothing taken, narrow loads flag register zero
    `CMP("busy", 1'b1, busy_o)
    `CMP("ready", 1'b0, instr_ready_o)
    `CMP("hazard", (k == 3 || k == 4), r0_hazard_o)
    instr_valid_i = 1'b0;
    t = 0;
    while (retire_o !== 1'b1 && t < 50) begin @(negedge clk_i); t++; end
    if (t >= 50) mismatches++;
    case (k)
      3: r[0] = {{24{v[7]}}, v[7:0]};
      4: r[0] = {{16{v[15]}}, v[15:0]};
      5: r[n] = v;
      6: r[0] = ((in_delay_slot_i ? branch_target_i + 32'h2 : instr_addr_i + 32'h4) & 32'hfffffffc) + {22'h0, d8, 2'h0};
      7: r[n] = {31'h0, flag_i};
      8: low_accumulator = r[n] * r[m];
      9: low_accumulator = $signed(r[n][15:0]) * $signed(r[m][15:0]);
      default: ;
    endcase
    if (k < 3) begin
      `CMP("addr", ea, u_mem.last_addr)
      `CMP("data", wd, u_mem.last_data)
      `CMP("size", k[1:0], u_mem.last_size)
    end
    `CMP("r0", r[0], general_register_zero_o)
    `CMP("low_accumulator", low_accumulator, low_accumulator_o)
    `CMP("high_accumulator", 32'h0, high_accumulator_o)
    `CMP("pc", instr_addr_i + PC_STEP, next_pc_o)
    `CMP("flag", flag_i, flag_o)
  endtask : step
  // ----
  // Sequence
  // ----
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin mismatches++; conclude(); end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) sys_rst_i = 0;
    for (int i = 1; i < 16; i++) step(5, 4'(i), 4'h0, 4'(i));
    $display("test register load done");
    for (int i = 0; i < 400; i++) step({$random(seed)} % 10, 4'($random(seed)), 4'($random(seed)), 4'($random(seed)));
    $display("test random mix done");
    conclude();
  end
endmodule : disp_move_and_multiply_exec_tb_top
